// ### flash_seq.sv
// command sequencer of a serial nor flash: quad reads, wrap setup, erases
// assumes SCLK, CS_N and SIO_IN come from the link and are oversampled here;
// QUAD_ENABLE and PROTECT_LEVEL_BITS come from logic on CLOCK
`timescale 1ns/1ps

// Operation
// - address sampled rising, nibble driven falling
// - read address increments, wraps to zero
// - 6B: opcode, 24 addr, 8 dummy, x4 data
// - quad reads rejected while busy
// - EB moves address, dummy, data four-wide
// - EB: address x4, 2+4 dummy, data
// - EB continuation byte, 4 dummy, then data
// - continuation 10 skips opcode next frame
// - other continuation code restores opcode expectation
// - continuation reset clears the code
// - 77: opcode, 24 dummy, wrap byte
// - wrap off bit, lengths 8/16/32/64
// - wrap applies to later EB reads
// - 81 clears addressed 256-byte page
// - erase needs write latch set first
// - sector by A12 up, 32K block
// - select must rise at byte boundary
// - busy during erase, latch cleared after
// - erase refused when its base address is protected
module flash_seq #(
  parameter int AW           = 16,
  parameter int PAGE_CYCLES  = flash_seq_pkg::PAGE_CLEAR_CYCLES,
  parameter int SMALL_CYCLES = flash_seq_pkg::SMALL_WIPE_CYCLES,
  parameter int HALF_CYCLES  = flash_seq_pkg::HALF_BLOCK_WIPE_CYCLES
) (
  input  wire logic       CLOCK,
  input  wire logic       RST_N,
  input  wire logic       SCLK,
  input  wire logic       CS_N,
  input  wire logic [3:0] SIO_IN,
  output logic      [3:0] SIO_OUT,
  output logic      [3:0] SIO_OE,
  input  wire logic       QUAD_ENABLE,
  input  wire logic [4:0] PROTECT_LEVEL_BITS,
  output logic            BUSY_FLAG,
  output logic            WRITE_LATCH
);

  // ****************************************
  // link sampling
  // ****************************************
  logic [5:0] sync_q;
  logic       sclk_d_q;
  logic       cs_d_q;
  logic       sclk_s;
  logic       cs_s;
  logic [3:0] sio_s;
  logic       rise;
  logic       fall;
  logic       frame_start;
  logic       frame_end;

  // select travels inverted so a cleared synchroniser reads as deselected,
  // otherwise a false frame edge would follow every reset
  signal_sync #(.W(6)) u_sync (
    .CLOCK (CLOCK),
    .RST_N (RST_N),
    .d     ({SCLK, ~CS_N, SIO_IN}),
    .q     (sync_q)
  );

  assign sclk_s = sync_q[5];
  assign cs_s   = ~sync_q[4];
  assign sio_s  = sync_q[3:0];

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      sclk_d_q <= 1'b0;
      cs_d_q   <= 1'b1;
    end else begin
      sclk_d_q <= sclk_s;
      cs_d_q   <= cs_s;
    end
  end

  assign rise        = !cs_s && sclk_s && !sclk_d_q;
  assign fall        = !cs_s && !sclk_s && sclk_d_q;
  assign frame_start = cs_d_q && !cs_s;
  assign frame_end   = !cs_d_q && cs_s;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [AW-1:0] next_addr(input logic [AW-1:0] a,
                                               input logic          wrap_on,
                                               input logic [1:0]    len);
    logic [AW-1:0] mask;
    logic [AW-1:0] inc;
    mask = AW'(8 << len) - AW'(1);
    inc  = a + AW'(1);
    if (wrap_on) begin
      next_addr = (a & ~mask) | (inc & mask);
    end else begin
      next_addr = inc;
    end
  endfunction

  // protection covers the top 1/2^(7-level) of the array; 0 covers none, 7 covers all
  function automatic logic covered(input logic [AW-1:0] a, input logic [2:0] lvl);
    logic hit;
    hit = (lvl != 3'h0);
    for (int i = 0; i < 7; i++) begin
      if (i < 7 - int'(lvl)) begin
        hit = hit & a[AW-1-i];
      end
    end
    covered = hit;
  endfunction

  // ****************************************
  // frame sequencer
  // ****************************************
  flash_seq_pkg::seq_state_t state_q;
  logic [7:0]    op_q;
  logic [4:0]    cnt_q;
  logic [4:0]    lim_q;
  logic [5:0]    wcnt_q;
  logic [23:0]   sh_q;
  logic [AW-1:0] addr_q;
  logic          cont_q;
  logic          cont_next_q;
  logic [2:0]    wrap_q;
  logic [2:0]    wrap_pend_q;
  logic          busy_q;
  logic          latch_q;
  logic [7:0]    op_in;
  logic [23:0]   sh1;
  logic [23:0]   sh4;
  logic [7:0]    rdata;
  logic          nib_lo_q;

  assign op_in = {sh_q[6:0], sio_s[0]};
  assign sh1   = {sh_q[22:0], sio_s[0]};       // upper lines ignored
  assign sh4   = {sh_q[19:0], sio_s};

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      state_q     <= flash_seq_pkg::ST_IDLE;
      op_q        <= 8'h00;
      cnt_q       <= 5'h00;
      lim_q       <= 5'h00;
      wcnt_q      <= 6'h00;
      sh_q        <= 24'h000000;
      addr_q      <= '0;
      cont_next_q <= 1'b0;
      wrap_pend_q <= flash_seq_pkg::WRAP_RESET;
    end else if (frame_end || cs_s) begin
      state_q <= flash_seq_pkg::ST_IDLE;
    end else if (frame_start) begin
      cnt_q       <= 5'h00;
      wcnt_q      <= 6'h00;
      cont_next_q <= 1'b0;
      if (cont_q) begin
        op_q <= flash_seq_pkg::OP_QUAD_ADDR_READ;
        // opcode skipped, address comes first
        state_q <= busy_q ? flash_seq_pkg::ST_HOLD : flash_seq_pkg::ST_ADDR4;
      end else begin
        state_q <= flash_seq_pkg::ST_OPCODE;
      end
    end else if (fall && state_q == flash_seq_pkg::ST_DATA && nib_lo_q) begin
      // byte done: step the address, with wrap only for EB
      addr_q <= next_addr(addr_q,
                          op_q == flash_seq_pkg::OP_QUAD_ADDR_READ && !wrap_q[0],
                          wrap_q[2:1]);
    end else if (rise) begin
      cnt_q <= cnt_q + 5'h01;
      case (state_q)
        flash_seq_pkg::ST_OPCODE: begin
          sh_q <= sh1;
          if (cnt_q == flash_seq_pkg::OPCODE_CLKS - 5'h01) begin
            op_q  <= op_in;
            cnt_q <= 5'h00;
            case (op_in)
              flash_seq_pkg::OP_QUAD_OUT_READ: begin
                state_q <= (busy_q || !QUAD_ENABLE) ? flash_seq_pkg::ST_HOLD
                                                    : flash_seq_pkg::ST_ADDR1;
              end
              flash_seq_pkg::OP_QUAD_ADDR_READ: begin
                state_q <= (busy_q || !QUAD_ENABLE) ? flash_seq_pkg::ST_HOLD
                                                    : flash_seq_pkg::ST_ADDR4;
              end
              flash_seq_pkg::OP_PAGE_CLEAR, flash_seq_pkg::OP_SMALL_AREA_WIPE,
              flash_seq_pkg::OP_HALF_BLOCK_WIPE, flash_seq_pkg::OP_BURST_WRAP_SETUP: begin
                state_q <= flash_seq_pkg::ST_ADDR1;
              end
              default: begin
                state_q <= flash_seq_pkg::ST_HOLD;
              end
            endcase
          end
        end
        flash_seq_pkg::ST_ADDR1: begin
          sh_q   <= sh1;
          wcnt_q <= wcnt_q + 6'h01;
          if (op_q == flash_seq_pkg::OP_BURST_WRAP_SETUP) begin
            // 24 dummy bits then the wrap byte, on one line
            if (wcnt_q == flash_seq_pkg::WRAP_FRAME_BITS - 6'h01) begin
              wrap_pend_q <= sh1[flash_seq_pkg::WRAP_BITS_LSB +: 3];
              state_q     <= flash_seq_pkg::ST_HOLD;
              cnt_q       <= 5'h00;
            end
          end else if (cnt_q == flash_seq_pkg::ADDR_X1_CLKS - 5'h01) begin
            addr_q <= sh1[AW-1:0];
            cnt_q  <= 5'h00;
            lim_q  <= flash_seq_pkg::QO_DUMMY_CLKS;
            state_q <= (op_q == flash_seq_pkg::OP_QUAD_OUT_READ) ? flash_seq_pkg::ST_DUMMY
                                                                 : flash_seq_pkg::ST_HOLD;
          end
        end
        flash_seq_pkg::ST_ADDR4: begin
          sh_q <= sh4;
          if (cnt_q == flash_seq_pkg::ADDR_X4_CLKS - 5'h01) begin
            addr_q  <= sh4[AW-1:0];
            cnt_q   <= 5'h00;
            state_q <= flash_seq_pkg::ST_MODE;
          end
        end
        flash_seq_pkg::ST_MODE: begin
          sh_q <= sh4;
          if (cnt_q == flash_seq_pkg::MODE_X4_CLKS - 5'h01) begin
            cont_next_q <= (sh4[flash_seq_pkg::CONT_CODE_LSB +: 2]
                            == flash_seq_pkg::CONT_CODE_KEEP);
            cnt_q   <= 5'h00;
            lim_q   <= flash_seq_pkg::QA_DUMMY_CLKS;
            state_q <= flash_seq_pkg::ST_DUMMY;
          end
        end
        flash_seq_pkg::ST_DUMMY: begin
          if (cnt_q == lim_q - 5'h01) begin
            state_q <= flash_seq_pkg::ST_DATA;
          end
        end
        flash_seq_pkg::ST_HOLD: begin
          // a clock past the byte boundary spoils any pending command
          op_q <= 8'h00;
        end
        default: begin
          state_q <= state_q;
        end
      endcase
    end
  end

  // ****************************************
  // continuation and wrap settings
  // ****************************************
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      cont_q <= 1'b0;
    end else if (frame_end) begin
      // anything short of a keep code, incl. the reset command, leaves
      cont_q <= cont_next_q;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      wrap_q <= flash_seq_pkg::WRAP_RESET;
    end else if (frame_end && state_q == flash_seq_pkg::ST_HOLD
                 && op_q == flash_seq_pkg::OP_BURST_WRAP_SETUP && !busy_q) begin
      wrap_q <= wrap_pend_q;
    end
  end

  // ****************************************
  // data output
  // ****************************************
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      SIO_OUT  <= 4'h0;
      SIO_OE   <= 4'h0;
      nib_lo_q <= 1'b0;
    end else if (state_q != flash_seq_pkg::ST_DATA) begin
      // released as soon as the host ends the frame
      SIO_OE   <= 4'h0;
      nib_lo_q <= 1'b0;
    end else if (fall) begin
      SIO_OUT  <= nib_lo_q ? rdata[3:0] : rdata[7:4];
      SIO_OE   <= 4'hF;
      nib_lo_q <= !nib_lo_q;
    end
  end

  // ****************************************
  // erase engine
  // ****************************************
  logic          launch;
  logic          is_erase;
  logic [AW-1:0] span;
  logic [AW-1:0] base;
  logic [31:0]   timer_q;
  logic [AW:0]   left_q;
  logic [AW-1:0] wipe_q;

  assign is_erase = op_q == flash_seq_pkg::OP_PAGE_CLEAR
                 || op_q == flash_seq_pkg::OP_SMALL_AREA_WIPE
                 || op_q == flash_seq_pkg::OP_HALF_BLOCK_WIPE;
  assign launch = frame_end && state_q == flash_seq_pkg::ST_HOLD && is_erase
                  && latch_q && !busy_q;

  always_comb begin
    case (op_q)
      flash_seq_pkg::OP_PAGE_CLEAR:      span = AW'(1) << flash_seq_pkg::PAGE_LOG2;
      flash_seq_pkg::OP_SMALL_AREA_WIPE: span = AW'(1) << flash_seq_pkg::SECTOR_LOG2;
      default:                           span = AW'(1) << flash_seq_pkg::HALF_LOG2;
    endcase
    base = addr_q & ~(span - AW'(1));
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      busy_q  <= 1'b0;
      timer_q <= 32'h00000000;
      left_q  <= '0;
      wipe_q  <= '0;
    end else if (launch && !covered(base, PROTECT_LEVEL_BITS[2:0])) begin
      busy_q <= 1'b1;
      wipe_q <= base;
      left_q <= {1'b0, span};
      case (op_q)
        flash_seq_pkg::OP_PAGE_CLEAR:      timer_q <= 32'(PAGE_CYCLES);
        flash_seq_pkg::OP_SMALL_AREA_WIPE: timer_q <= 32'(SMALL_CYCLES);
        default:                           timer_q <= 32'(HALF_CYCLES);
      endcase
    end else if (busy_q) begin
      if (timer_q != 32'h00000000) begin
        timer_q <= timer_q - 32'h00000001;
      end
      if (left_q != '0) begin
        left_q <= left_q - (AW+1)'(1);
        wipe_q <= wipe_q + AW'(1);
      end
      if (timer_q <= 32'h00000001 && left_q <= (AW+1)'(1)) begin
        busy_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      latch_q <= 1'b0;
    end else if (busy_q && timer_q <= 32'h00000001 && left_q <= (AW+1)'(1)) begin
      latch_q <= 1'b0;
    end else if (launch && op_q == flash_seq_pkg::OP_HALF_BLOCK_WIPE) begin
      latch_q <= !covered(base, PROTECT_LEVEL_BITS[2:0]) && latch_q;
    end else if (frame_end && state_q == flash_seq_pkg::ST_HOLD && !busy_q
                 && op_q == flash_seq_pkg::OP_WRITE_ARM) begin
      latch_q <= 1'b1;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      BUSY_FLAG   <= 1'b0;
      WRITE_LATCH <= 1'b0;
    end else begin
      BUSY_FLAG   <= busy_q;
      WRITE_LATCH <= latch_q;
    end
  end

  // ****************************************
  // storage
  // ****************************************
  flash_array #(.AW(AW)) u_array (
    .CLOCK (CLOCK),
    .we    (busy_q && left_q != '0),
    .waddr (wipe_q),
    .wdata (8'hFF),
    .raddr (addr_q),
    .rdata (rdata)
  );

endmodule

// ### flash_seq_pkg.sv
// constants shared by the serial flash command sequencer and its helpers
// assumes a single 250 MHz system clock that oversamples the serial link
package flash_seq_pkg;

  // ****************************************
  // opcodes
  // ****************************************
  localparam logic [7:0] OP_QUAD_OUT_READ    = 8'h6B;
  localparam logic [7:0] OP_QUAD_ADDR_READ   = 8'hEB;
  localparam logic [7:0] OP_BURST_WRAP_SETUP = 8'h77;
  localparam logic [7:0] OP_PAGE_CLEAR       = 8'h81;
  localparam logic [7:0] OP_SMALL_AREA_WIPE  = 8'h20;
  localparam logic [7:0] OP_HALF_BLOCK_WIPE  = 8'h52;
  localparam logic [7:0] OP_WRITE_ARM        = 8'h06;

  // ****************************************
  // frame layout, in serial clocks
  // ****************************************
  localparam logic [4:0] OPCODE_CLKS     = 5'h08;
  localparam logic [4:0] ADDR_X1_CLKS    = 5'h18;
  localparam logic [4:0] ADDR_X4_CLKS    = 5'h06;
  localparam logic [4:0] MODE_X4_CLKS    = 5'h02;
  localparam logic [4:0] QO_DUMMY_CLKS   = 5'h08;
  localparam logic [4:0] QA_DUMMY_CLKS   = 5'h04;
  localparam logic [5:0] WRAP_FRAME_BITS = 6'h20;

  // ****************************************
  // fields and reset values
  // ****************************************
  localparam logic [1:0] CONT_CODE_KEEP = 2'h2;
  localparam int         CONT_CODE_LSB  = 4;
  localparam int         WRAP_BITS_LSB  = 4;
  localparam logic [2:0] WRAP_RESET     = 3'h7;
  localparam int         PAGE_LOG2      = 8;
  localparam int         SECTOR_LOG2    = 12;
  localparam int         HALF_LOG2      = 15;

  // ****************************************
  // self-timed erase durations
  // ****************************************
  localparam int CLOCK_MHZ                 = 250;
  localparam int PAGE_CLEAR_TIME_US        = 100;
  localparam int SMALL_WIPE_TIME_US        = 200;
  localparam int HALF_BLOCK_WIPE_TIME_US   = 500;
  localparam int PAGE_CLEAR_CYCLES         = PAGE_CLEAR_TIME_US * CLOCK_MHZ;
  localparam int SMALL_WIPE_CYCLES         = SMALL_WIPE_TIME_US * CLOCK_MHZ;
  localparam int HALF_BLOCK_WIPE_CYCLES    = HALF_BLOCK_WIPE_TIME_US * CLOCK_MHZ;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_OPCODE = 3'b001,
    ST_ADDR1  = 3'b010,
    ST_ADDR4  = 3'b011,
    ST_MODE   = 3'b100,
    ST_DUMMY  = 3'b101,
    ST_DATA   = 3'b110,
    ST_HOLD   = 3'b111
  } seq_state_t;

endpackage

// ### signal_sync.sv
// two-stage synchroniser for a bundle of asynchronous levels
// assumes each bit is a slow level relative to CLOCK
`timescale 1ns/1ps
module signal_sync #(
  parameter int W = 1
) (
  input  wire logic         CLOCK,
  input  wire logic         RST_N,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule

// ### flash_array.sv
// byte-wide storage array with one write port and one registered read port
// assumes contents are undefined until erased; no reset on the storage
`timescale 1ns/1ps
module flash_array #(
  parameter int AW = 16
) (
  input  wire logic          CLOCK,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [7:0]    wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [7:0]    rdata
);
  logic [7:0] mem [0:(1<<AW)-1];

  always_ff @(posedge CLOCK) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge CLOCK) begin
    rdata <= mem[raddr];
  end
endmodule

// ### flash_seq_checker.sv
// port assertions for the serial flash command sequencer
// assumes one CLOCK domain and a synchronous active-low RST_N
`timescale 1ns/1ps
module flash_seq_checker (
  input wire logic       CLOCK,
  input wire logic       RST_N,
  input wire logic       SCLK,
  input wire logic       CS_N,
  input wire logic [3:0] SIO_IN,
  input wire logic [3:0] SIO_OUT,
  input wire logic [3:0] SIO_OE,
  input wire logic       QUAD_ENABLE,
  input wire logic [4:0] PROTECT_LEVEL_BITS,
  input wire logic       BUSY_FLAG,
  input wire logic       WRITE_LATCH
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_N);

  // ****************************************
  // helpers
  // ****************************************
  // remembers a frame that opened while an erase was running
  logic busy_frame_q;
  always_ff @(posedge CLOCK) begin
    if (!RST_N || CS_N) busy_frame_q <= 1'b0;
    else if ($fell(CS_N) && BUSY_FLAG) busy_frame_q <= 1'b1;
  end

  sequence deselect_s;
    $rose(CS_N) ##1 CS_N [*6];
  endsequence
  sequence erase_start_s;
    $rose(BUSY_FLAG) ##0 CS_N;
  endsequence

  // ****************************************
  // assertions
  // ****************************************
  chk_cs_release: assert property (deselect_s |-> SIO_OE == 4'h0)
    else $error("data lines still driven after deselect");
  chk_oe_whole: assert property (SIO_OE != 4'h0 |-> SIO_OE == 4'hF && QUAD_ENABLE)
    else $error("partial or unpermitted drive of data lines");
  chk_busy_read: assert property (busy_frame_q |-> SIO_OE == 4'h0)
    else $error("read answered while erase running");
  chk_nibble_edge: assert property ($changed(SIO_OUT) && SIO_OE == 4'hF |-> !SCLK && !$past(SCLK, 2))
    else $error("nibble changed outside the low phase");
  chk_drive_start: assert property ($rose(SIO_OE[0]) |-> !CS_N && !SCLK)
    else $error("drive began outside a selected low phase");
  chk_busy_arm: assert property (erase_start_s |-> $past(WRITE_LATCH))
    else $error("erase began without write latch");
  chk_busy_end: assert property ($fell(BUSY_FLAG) |-> !WRITE_LATCH)
    else $error("write latch kept after erase end");
  chk_latch_arm: assert property ($rose(WRITE_LATCH) |-> CS_N && !BUSY_FLAG)
    else $error("write latch set inside a frame or while busy");
endmodule

bind flash_seq flash_seq_checker i_chk (.CLOCK(CLOCK), .RST_N(RST_N), .SCLK(SCLK), .CS_N(CS_N),
  .SIO_IN(SIO_IN), .SIO_OUT(SIO_OUT), .SIO_OE(SIO_OE), .QUAD_ENABLE(QUAD_ENABLE),
  .PROTECT_LEVEL_BITS(PROTECT_LEVEL_BITS), .BUSY_FLAG(BUSY_FLAG), .WRITE_LATCH(WRITE_LATCH));

// ### spi_host_model.sv
// host serial flash controller model: frames, x1 and x4 transfers
// assumes CLOCK is the bench clock; a serial clock half period is 20 CLOCKs
`timescale 1ns/1ps
module spi_host_model (
  input  wire logic       CLOCK,
  input  wire logic [3:0] SIO_PIN,
  output logic            SCLK,
  output logic            CS_N,
  output logic      [3:0] SIO_DRV,
  output logic      [3:0] SIO_EN
);
  logic [7:0] rx_byte;

  // serial clock stands low outside frames
  initial begin
    SCLK = 1'b0;
    CS_N = 1'b1;
    SIO_DRV = 4'h0;
    SIO_EN = 4'h0;
    rx_byte = 8'h00;
  end

  task automatic half();
    repeat (20) @(posedge CLOCK);
    #1;
  endtask

  // data set in the low phase, both sides sample at the rise
  task automatic tick(input logic [3:0] d, input logic [3:0] e);
    SIO_DRV = d;
    SIO_EN = e;
    half();
    SCLK = 1'b1;
    rx_byte = {rx_byte[3:0], SIO_PIN};
    half();
    SCLK = 1'b0;
  endtask

  task automatic start();
    CS_N = 1'b0;
  endtask

  // ending at any point of a frame is allowed
  task automatic stop();
    SIO_EN = 4'h0;
    half();
    CS_N = 1'b1;
    repeat (10) @(posedge CLOCK);
    #1;
  endtask

  // upper lines carry noise so that a device using them is caught
  task automatic tx1(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) tick({3'h5, b[i]}, 4'hF);
  endtask

  task automatic tx4(input logic [23:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) tick(v[4*i +: 4], 4'hF);
  endtask

  task automatic idle(input int n);
    repeat (n) tick(4'h0, 4'h0);
  endtask

  // high nibble first
  task automatic rx(output logic [7:0] b);
    tick(4'h0, 4'h0);
    tick(4'h0, 4'h0);
    b = rx_byte;
  endtask
endmodule

// ### tb_top.sv
// self-checking bench for the flash command sequencer with a host model
// assumes the package opcodes, a 250 MHz clock and a 160 ns serial clock
`timescale 1ns/1ps
module tb_top;
  logic       clock, rst_n, quad_enable_bit, drove_q, busy_flag, write_latch, sclk, cs_n;
  logic [3:0] sio_drv, sio_en, sio_out, sio_oe, sio_pin, idle_q;
  logic [4:0] protect_level_bits;
  int         fails, n_tests;

  // released lines show a moving pattern so a missing drive cannot read as data
  assign sio_pin = (sio_oe & sio_out) | (~sio_oe & sio_en & sio_drv) | (~sio_oe & ~sio_en & idle_q);
  always @(posedge sclk) idle_q <= idle_q + 4'h3;
  always @(posedge clock) if (sio_oe != 4'h0) drove_q <= 1'b1;
  always #2 clock = ~clock;

  flash_seq #(.PAGE_CYCLES(4000), .SMALL_CYCLES(5000), .HALF_CYCLES(40000)) i_dut (
    .CLOCK(clock), .RST_N(rst_n), .SCLK(sclk), .CS_N(cs_n), .SIO_IN(sio_pin),
    .SIO_OUT(sio_out), .SIO_OE(sio_oe), .QUAD_ENABLE(quad_enable_bit),
    .PROTECT_LEVEL_BITS(protect_level_bits), .BUSY_FLAG(busy_flag), .WRITE_LATCH(write_latch));
  spi_host_model i_host (.CLOCK(clock), .SIO_PIN(sio_pin), .SCLK(sclk), .CS_N(cs_n),
    .SIO_DRV(sio_drv), .SIO_EN(sio_en));

  // ****************************************
  // tasks
  // ****************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    if (fails == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // opcode, nb bytes of v, then extra clocks that break the byte boundary
  task automatic cmd(input logic [7:0] op, input int nb, input logic [31:0] v, input int extra);
    i_host.start();
    i_host.tx1(op);
    for (int i = nb - 1; i >= 0; i--) i_host.tx1(v[8*i +: 8]);
    i_host.idle(extra);
    i_host.stop();
  endtask

  // erased bytes read back as FF wherever the device drives
  task automatic read(input logic x4, input logic op, input logic [23:0] a, input logic [7:0] m,
                      input int n, input logic drive);
    logic [7:0] b;
    drove_q = 1'b0;
    i_host.start();
    if (!x4) begin
      i_host.tx1(flash_seq_pkg::OP_QUAD_OUT_READ);
      for (int i = 2; i >= 0; i--) i_host.tx1(a[8*i +: 8]);
      i_host.idle(8);
    end else begin
      if (op) i_host.tx1(flash_seq_pkg::OP_QUAD_ADDR_READ);
      i_host.tx4(a, 6);
      i_host.tx4({16'h0000, m}, 2);
      i_host.idle(4);
    end
    for (int i = 0; i < n; i++) begin
      i_host.rx(b);
      if (drive) check(b, 8'hFF);
    end
    i_host.stop();
    check(drove_q, drive);
  endtask

  task automatic wait_idle();
    for (int i = 0; i < 10000 && busy_flag !== 1'b0; i++) @(posedge clock);
    #1;
    check(busy_flag, 1'b0);
  endtask

  // ****************************************
  // tests
  // ****************************************
  initial begin
    clock = 1'b0;
    rst_n = 1'b0;
    quad_enable_bit = 1'b1;
    protect_level_bits = 5'h00;
    drove_q = 1'b0;
    idle_q = 4'h0;
    fails = 0;
    n_tests = 0;
    repeat (2) @(posedge clock);
    #1 rst_n = 1'b1;
    repeat (8) @(posedge clock);
    #1;
    check(busy_flag, 1'b0);
    check(write_latch, 1'b0);
    cmd(flash_seq_pkg::OP_PAGE_CLEAR, 3, 32'h0000_0100, 0);
    check(busy_flag, 1'b0);
    cmd(flash_seq_pkg::OP_WRITE_ARM, 0, 32'h0, 0);
    check(write_latch, 1'b1);
    cmd(flash_seq_pkg::OP_PAGE_CLEAR, 3, 32'h0000_0100, 0);
    check(busy_flag, 1'b1);
    read(1'b0, 1'b1, 24'h000100, 8'h00, 1, 1'b0);
    check(write_latch, 1'b1);
    wait_idle();
    check(write_latch, 1'b0);
    read(1'b0, 1'b1, 24'h0001FE, 8'h00, 2, 1'b1);
    quad_enable_bit = 1'b0;
    read(1'b0, 1'b1, 24'h000100, 8'h00, 1, 1'b0);
    read(1'b1, 1'b1, 24'h000100, 8'h00, 1, 1'b0);
    quad_enable_bit = 1'b1;
    read(1'b1, 1'b1, 24'h000180, 8'h20, 1, 1'b1);
    read(1'b1, 1'b0, 24'h0001C0, 8'h00, 1, 1'b1);
    read(1'b1, 1'b0, 24'h0001C0, 8'h00, 1, 1'b0);
    cmd(flash_seq_pkg::OP_BURST_WRAP_SETUP, 4, 32'h0000_0000, 0);
    read(1'b1, 1'b1, 24'h0001FE, 8'h00, 3, 1'b1);
    cmd(flash_seq_pkg::OP_BURST_WRAP_SETUP, 4, 32'h0000_0010, 0);
    cmd(flash_seq_pkg::OP_WRITE_ARM, 0, 32'h0, 0);
    cmd(flash_seq_pkg::OP_SMALL_AREA_WIPE, 3, 32'h0000_1234, 1);
    check(busy_flag, 1'b0);
    cmd(flash_seq_pkg::OP_SMALL_AREA_WIPE, 3, 32'h0000_1234, 0);
    check(busy_flag, 1'b1);
    wait_idle();
    check(write_latch, 1'b0);
    read(1'b0, 1'b1, 24'h001FFE, 8'h00, 2, 1'b1);
    protect_level_bits = 5'h07;
    cmd(flash_seq_pkg::OP_WRITE_ARM, 0, 32'h0, 0);
    cmd(flash_seq_pkg::OP_PAGE_CLEAR, 3, 32'h0000_0100, 0);
    check(busy_flag, 1'b0);
    check(write_latch, 1'b1);
    cmd(flash_seq_pkg::OP_HALF_BLOCK_WIPE, 3, 32'h0000_4000, 0);
    wait_idle();
    check(write_latch, 1'b0);
    report_and_stop();
  end

  // the tests need about 120 us; two and a half times that means a hang
  initial begin
    #300000;
    fails++;
    report_and_stop();
  end
endmodule
